// >>> core/codec_frame_pkg.sv
// shared constants, carriers and field layout of the speech codec frame interface
package codec_frame_pkg;

  // ****************************************
  // word and frame geometry
  // ****************************************
  localparam int WORD_W           = 16;
  localparam int SAMPLE_BITS      = 13;
  localparam int PAD_BITS         = WORD_W - SAMPLE_BITS;
  localparam int FRAME_WORDS      = 76;
  localparam int FRAME_MS         = 20;
  localparam int SAMPLE_RATE_HZ   = 8000;
  localparam int FRAME_SAMPLES    = SAMPLE_RATE_HZ * FRAME_MS / 1000;
  localparam int LAR_COUNT        = 8;
  localparam int SUB_WORDS        = 17;
  localparam int LAG_W            = 7;
  localparam int GAIN_W           = 2;
  localparam int GRID_W           = 2;
  localparam int AMP_W            = 6;
  localparam int PULSE_W          = 3;
  localparam int SUB_LAG          = 0;
  localparam int SUB_GAIN         = 1;
  localparam int SUB_GRID         = 2;
  localparam int SUB_AMP          = 3;

  // ****************************************
  // timing
  // ****************************************
  localparam longint CLK_HZ       = 64'd200_000_000;
  localparam int SAMPLE_PERIOD_CYC = int'(CLK_HZ / SAMPLE_RATE_HZ);

  localparam logic [WORD_W-1:0] PAD_MASK = 16'hfff8;

  typedef logic [WORD_W-1:0] word_t;

  typedef struct packed {
    logic  frame_start;
    word_t data;
  } coded_word_t;

  // widths of the log-area code pairs at the head of a frame
  localparam int LAR_W12          = 6;
  localparam int LAR_W34          = 5;
  localparam int LAR_W56          = 4;
  localparam int LAR_W78          = 3;

  // width of the right-justified field held by word idx of a frame
  function automatic int field_width(input int idx);
    int sub;
    sub = 0;
    if (idx < LAR_COUNT) begin
      case (idx)
        0, 1:    field_width = LAR_W12;
        2, 3:    field_width = LAR_W34;
        4, 5:    field_width = LAR_W56;
        default: field_width = LAR_W78;
      endcase
    end else begin
      sub = (idx - LAR_COUNT) % SUB_WORDS;
      case (sub)
        SUB_LAG:  field_width = LAG_W;
        SUB_GAIN: field_width = GAIN_W;
        SUB_GRID: field_width = GRID_W;
        SUB_AMP:  field_width = AMP_W;
        default:  field_width = PULSE_W;
      endcase
    end
  endfunction

endpackage

// >>> core/skid_buffer2.sv
// two-entry valid/ready buffer
`timescale 1ns/10ps
`default_nettype none
module skid_buffer2
  import codec_frame_pkg::*;
#(
  parameter int W = 17
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  logic [W-1:0] mem_r [2];
  logic         wr_ptr_r;
  logic         rd_ptr_r;
  logic [1:0]   count_r;
  logic         push;
  logic         pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  AST_NO_OVERFILL: assert property (@(posedge core_clk) disable iff (rst) count_r <= 2'h2)
    else $error("buffer count above two");

endmodule
`default_nettype wire

// >>> core/speech_codec_frame_io.sv
// frame-level input/output, homing and state initialisation of the speech transcoder
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - all exchanged words are sixteen bits
// - 76 coded words per 20 ms frame
// - encoder takes 8 kHz samples without stall
// - external reset initialises encoder state
// - external reset initialises decoder state
// - homing detection initialises state without reset
// - homing frames reset all state variables; playout tick, overrun flag and output buffer keep theirs
// - first encoder frame after homing unconstrained
// - first decoder frame after homing unconstrained
// - without homing, encoder output matches reference
// - decoder plays samples continuously at 8 kHz
// - input sample: 13 bits, left-justified
// - output sample: three low bits zero
// - eight log-area codes, widths 6..3, first
module speech_codec_frame_io
  import codec_frame_pkg::*;
#(
  parameter int    SAMPLE_PERIOD = SAMPLE_PERIOD_CYC,
  parameter word_t ENC_HOME_WORD = 16'h0000,
  parameter word_t DEC_HOME_WORD = 16'h0000
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        codec_state_reset,
  input  wire logic        enc_in_valid,
  input  wire word_t       enc_in_sample,
  output logic             enc_core_valid,
  output word_t            enc_core_sample,
  output logic             enc_frame_end,
  input  wire logic        core_param_wr,
  input  wire logic [6:0]  core_param_addr,
  input  wire word_t       core_param_data,
  input  wire logic        core_params_done,
  output coded_word_t      enc_out,
  output logic             enc_out_valid,
  input  wire logic        enc_out_ready,
  output logic             enc_overrun,
  input  wire logic        dec_in_valid,
  input  wire word_t       dec_in_word,
  output logic             dec_in_ready,
  output logic             dec_frame_ready,
  input  wire logic [6:0]  core_dec_addr,
  output word_t            dec_param_q,
  input  wire logic        core_smp_wr,
  input  wire logic [7:0]  core_smp_addr,
  input  wire word_t       core_smp_data,
  output logic             dec_out_valid,
  output word_t            dec_out_sample,
  output logic             state_init
);

  if (SAMPLE_PERIOD < 2 || FRAME_SAMPLES > 256 || FRAME_WORDS > 128) begin : g_bad_geometry
    $error("unsupported period or frame geometry");
  end

  typedef enum logic {TX_IDLE, TX_STREAM} tx_state_t;

  // keeps only the documented field bits of word idx
  function automatic word_t mask_field(input int idx, input word_t w);
    word_t m;
    m = word_t'((17'h1 << field_width(idx)) - 17'h1);
    mask_field = w & m;
  endfunction

  // ****************************************
  // state reset pin and state initialisation
  // ****************************************
  logic  rs_meta_r;
  logic  rs_sync_r;
  logic  rs_prev_r;
  logic  rs_rise;
  logic  enc_home_r;
  logic  dec_home_r;
  logic  state_init_r;
  logic  enc_end_r;
  logic  dec_end_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rs_meta_r <= 1'b0;
      rs_sync_r <= 1'b0;
      rs_prev_r <= 1'b0;
    end else begin
      rs_meta_r <= codec_state_reset;
      rs_sync_r <= rs_meta_r;
      rs_prev_r <= rs_sync_r;
    end
  end

  assign rs_rise = rs_sync_r && !rs_prev_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_init_r <= 1'b1;
    end else begin
      state_init_r <= rs_rise
                   || (enc_end_r && enc_home_r)
                   || (dec_end_r && dec_home_r);
    end
  end

  assign state_init = state_init_r;

  // ****************************************
  // encoder input side
  // ****************************************
  logic [7:0] enc_cnt_r;
  word_t      enc_core_sample_r;
  logic       enc_core_valid_r;

  always_ff @(posedge core_clk) begin
    if (rst || state_init_r) begin
      enc_cnt_r        <= 8'h00;
      enc_end_r        <= 1'b0;
      enc_home_r       <= 1'b0;
      enc_core_valid_r <= 1'b0;
    end else begin
      enc_core_valid_r <= enc_in_valid;
      enc_end_r        <= enc_in_valid && (enc_cnt_r == 8'(FRAME_SAMPLES - 1));
      if (enc_in_valid) begin
        enc_home_r <= (enc_cnt_r == 8'h00 || enc_home_r) && (enc_in_sample == ENC_HOME_WORD);
        enc_cnt_r  <= (enc_cnt_r == 8'(FRAME_SAMPLES - 1)) ? 8'h00 : enc_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      enc_core_sample_r <= 16'h0000;
    end else if (enc_in_valid) begin
      enc_core_sample_r <= enc_in_sample & PAD_MASK;
    end
  end

  assign enc_core_valid  = enc_core_valid_r;
  assign enc_core_sample = enc_core_sample_r;
  assign enc_frame_end   = enc_end_r;

  // ****************************************
  // encoder output stream
  // ****************************************
  word_t       param_mem [FRAME_WORDS];
  tx_state_t   tx_state_r;
  logic [6:0]  tx_idx_r;
  logic        overrun_r;
  logic        buf_ready;
  logic        push;
  coded_word_t push_word;

  always_ff @(posedge core_clk) begin
    if (core_param_wr) begin
      param_mem[core_param_addr] <= core_param_data;
    end
  end

  assign push                  = (tx_state_r == TX_STREAM) && buf_ready;
  assign push_word.frame_start = (tx_idx_r == 7'h00);
  assign push_word.data        = mask_field(int'(tx_idx_r), param_mem[tx_idx_r]);

  always_ff @(posedge core_clk) begin
    if (rst || state_init_r) begin
      tx_state_r <= TX_IDLE;
      tx_idx_r   <= 7'h00;
    end else begin
      case (tx_state_r)
        TX_IDLE: begin
          tx_idx_r <= 7'h00;
          if (core_params_done) begin
            tx_state_r <= TX_STREAM;
          end
        end
        TX_STREAM: begin
          if (push) begin
            if (tx_idx_r == 7'(FRAME_WORDS - 1)) begin
              tx_state_r <= TX_IDLE;
              tx_idx_r   <= 7'h00;
            end else begin
              tx_idx_r <= tx_idx_r + 7'h01;
            end
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // a new frame while the last is still leaving is a real-time miss
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overrun_r <= 1'b0;
    end else if (core_params_done && tx_state_r == TX_STREAM) begin
      overrun_r <= 1'b1;
    end
  end

  assign enc_overrun = overrun_r;

  skid_buffer2 #(
    .W ($bits(coded_word_t))
  ) u_out_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (push_word),
    .in_valid  (tx_state_r == TX_STREAM),
    .in_ready  (buf_ready),
    .out_data  (enc_out),
    .out_valid (enc_out_valid),
    .out_ready (enc_out_ready)
  );

  // ****************************************
  // decoder input side
  // ****************************************
  word_t      dec_mem [FRAME_WORDS];
  logic [6:0] dec_cnt_r;
  word_t      dec_q_r;

  assign dec_in_ready = 1'b1;

  always_ff @(posedge core_clk) begin
    if (dec_in_valid) begin
      dec_mem[dec_cnt_r] <= mask_field(int'(dec_cnt_r), dec_in_word);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || state_init_r) begin
      dec_cnt_r  <= 7'h00;
      dec_end_r  <= 1'b0;
      dec_home_r <= 1'b0;
    end else begin
      dec_end_r <= dec_in_valid && (dec_cnt_r == 7'(FRAME_WORDS - 1));
      if (dec_in_valid) begin
        dec_home_r <= (dec_cnt_r == 7'h00 || dec_home_r) && (dec_in_word == DEC_HOME_WORD);
        dec_cnt_r  <= (dec_cnt_r == 7'(FRAME_WORDS - 1)) ? 7'h00 : dec_cnt_r + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dec_q_r <= 16'h0000;
    end else begin
      dec_q_r <= dec_mem[core_dec_addr];
    end
  end

  assign dec_frame_ready = dec_end_r;
  assign dec_param_q     = dec_q_r;

  // ****************************************
  // decoder output playout
  // ****************************************
  word_t       smp_mem [FRAME_SAMPLES];
  logic [31:0] tick_cnt_r;
  logic [7:0]  play_idx_r;
  logic        play_valid_r;
  word_t       play_smp_r;

  always_ff @(posedge core_clk) begin
    if (core_smp_wr) begin
      smp_mem[core_smp_addr] <= core_smp_data;
    end
  end

  // free-running 8 kHz tick keeps the output stream unbroken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_r   <= 32'h0;
      play_idx_r   <= 8'h00;
      play_valid_r <= 1'b0;
      play_smp_r   <= 16'h0000;
    end else begin
      play_valid_r <= (tick_cnt_r == 32'(SAMPLE_PERIOD - 1));
      if (tick_cnt_r == 32'(SAMPLE_PERIOD - 1)) begin
        tick_cnt_r <= 32'h0;
        play_smp_r <= smp_mem[play_idx_r] & PAD_MASK;
        play_idx_r <= (play_idx_r == 8'(FRAME_SAMPLES - 1)) ? 8'h00 : play_idx_r + 8'h01;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h1;
      end
    end
  end

  assign dec_out_valid  = play_valid_r;
  assign dec_out_sample = play_smp_r;

  // ****************************************
  // checks
  // ****************************************
  logic [31:0] gap_r;
  logic        seen_r;
  logic [6:0]  out_cnt_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gap_r  <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= play_valid_r ? 32'h1 : gap_r + 32'h1;
      seen_r <= seen_r || play_valid_r;
    end
  end

  // counts words leaving the buffer, independent of the stream index
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_cnt_r <= 7'h00;
    end else if (enc_out_valid && enc_out_ready) begin
      out_cnt_r <= (out_cnt_r == 7'(FRAME_WORDS - 1)) ? 7'h00 : out_cnt_r + 7'h01;
    end
  end

  AST_FRAME_START_FIRST: assert property (@(posedge core_clk) disable iff (rst)
    (enc_out_valid && enc_out_ready) |-> (enc_out.frame_start == (out_cnt_r == 7'h00)))
    else $error("frame-start strobe misplaced");
  AST_FRAME_76_WORDS: assert property (@(posedge core_clk) disable iff (rst)
    (push && tx_idx_r == 7'(FRAME_WORDS - 1)) |=> (tx_state_r == TX_IDLE)) else $error("frame not 76 words");
  AST_FIELD_WIDTH: assert property (@(posedge core_clk) disable iff (rst)
    push |-> ((push_word.data >> field_width(int'(tx_idx_r))) == 16'h0000)) else $error("field wider than its code");
  AST_LAR_FIRST: assert property (@(posedge core_clk) disable iff (rst)
    (push && tx_idx_r == 7'h00) |-> (push_word.data[15:6] == 10'h000)) else $error("first log-area code too wide");
  AST_OUT_PAD_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    dec_out_valid |-> (dec_out_sample[2:0] == 3'h0)) else $error("output sample low bits not zero");
  AST_IN_PAD_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    enc_core_valid |-> (enc_core_sample[2:0] == 3'h0)) else $error("input sample not 13 bits");
  AST_PLAYOUT_PERIOD: assert property (@(posedge core_clk) disable iff (rst)
    (dec_out_valid && seen_r) |-> (gap_r == 32'(SAMPLE_PERIOD))) else $error("output sample spacing wrong");
  AST_ENC_FRAME_END: assert property (@(posedge core_clk) disable iff (rst || state_init_r)
    (enc_in_valid && enc_cnt_r == 8'(FRAME_SAMPLES - 1)) |=> enc_frame_end) else $error("encoder frame end missed");
  AST_DEC_FRAME: assert property (@(posedge core_clk) disable iff (rst || state_init_r)
    (dec_in_valid && dec_cnt_r == 7'(FRAME_WORDS - 1)) |=> dec_frame_ready) else $error("decoder frame not flagged");
  AST_HOME_INIT: assert property (@(posedge core_clk) disable iff (rst)
    (enc_end_r && enc_home_r) |=> state_init) else $error("homing frame ignored");
  AST_PIN_RESET_INIT: assert property (@(posedge core_clk) disable iff (rst)
    $rose(rs_sync_r) |-> ##[1:2] state_init) else $error("state reset pin ignored");

  COV_ENC_FRAME: cover property (@(posedge core_clk) disable iff (rst) push && tx_idx_r == 7'(FRAME_WORDS - 1));
  COV_DEC_FRAME: cover property (@(posedge core_clk) disable iff (rst) dec_frame_ready);
  COV_HOMING: cover property (@(posedge core_clk) disable iff (rst) dec_end_r && dec_home_r);
  COV_STALL: cover property (@(posedge core_clk) disable iff (rst) (tx_state_r == TX_STREAM) && !buf_ready);

endmodule
`default_nettype wire

// >>> core/unused_placeholder_never.sv
// intentionally empty compilation unit
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> tb/harness_model.sv
// harness model: paced sample source, coded word source and stalling sink
`timescale 1ns/10ps
`default_nettype none
module harness_model
  import codec_frame_pkg::*;
(
  input  wire logic core_clk,
  output logic      enc_in_valid,
  output word_t     enc_in_sample,
  output logic      dec_in_valid,
  output word_t     dec_in_word,
  output logic      enc_out_ready
);
  logic stall;
  int   cyc;
  initial begin
    stall         = 1'b0;
    cyc           = 0;
    enc_in_valid  = 1'b0;
    enc_in_sample = 16'h0000;
    dec_in_valid  = 1'b0;
    dec_in_word   = 16'h0000;
    enc_out_ready = 1'b1;
  end
  // sink refuses two cycles in four when stalling
  always @(posedge core_clk) begin
    cyc           <= cyc + 1;
    enc_out_ready <= !(stall && cyc[1]);
  end
  // one sample per period, line inverted between samples
  task automatic send_smp(input word_t v, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      enc_in_valid  <= 1'b1;
      enc_in_sample <= v;
      @(posedge core_clk);
      enc_in_valid  <= 1'b0;
      enc_in_sample <= ~v;
      repeat (gap) @(posedge core_clk);
    end
  endtask
  // whole frame back to back, well inside one frame time
  task automatic send_dec(input word_t w[$]);
    // words in the state-init cycle after a frame are dropped, so start late
    repeat (2) @(posedge core_clk);
    foreach (w[i]) begin
      @(posedge core_clk);
      dec_in_valid <= 1'b1;
      dec_in_word  <= w[i];
    end
    @(posedge core_clk);
    dec_in_valid <= 1'b0;
    dec_in_word  <= ~w[w.size()-1];
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench of the speech codec frame interface
`timescale 1ns/10ps
`default_nettype none
module tb;
  import codec_frame_pkg::*;
  localparam int    SP  = 20;
  localparam word_t EHW = 16'h1230;
  localparam word_t DHW = 16'h0005;
  logic        core_clk, rst, codec_state_reset, enc_in_valid, enc_core_valid, enc_frame_end;
  logic        core_param_wr, core_params_done, enc_out_valid, enc_out_ready, enc_overrun;
  logic        dec_in_valid, dec_in_ready, dec_frame_ready, core_smp_wr, dec_out_valid, state_init;
  logic [6:0]  core_param_addr, core_dec_addr;
  logic [7:0]  core_smp_addr;
  word_t       enc_in_sample, enc_core_sample, core_param_data, dec_in_word, dec_param_q;
  word_t       core_smp_data, dec_out_sample, last_core;
  coded_word_t enc_out;
  coded_word_t got[$];
  int          fails = 0, n_checks = 0, n_core = 0, n_end = 0, n_init = 0, n_frm = 0, n_play = 0, n_got = 0;

  speech_codec_frame_io #(.SAMPLE_PERIOD(SP), .ENC_HOME_WORD(EHW), .DEC_HOME_WORD(DHW)) u_dut (
    .core_clk(core_clk), .rst(rst), .codec_state_reset(codec_state_reset),
    .enc_in_valid(enc_in_valid), .enc_in_sample(enc_in_sample), .enc_core_valid(enc_core_valid),
    .enc_core_sample(enc_core_sample), .enc_frame_end(enc_frame_end), .core_param_wr(core_param_wr),
    .core_param_addr(core_param_addr), .core_param_data(core_param_data),
    .core_params_done(core_params_done), .enc_out(enc_out), .enc_out_valid(enc_out_valid),
    .enc_out_ready(enc_out_ready), .enc_overrun(enc_overrun), .dec_in_valid(dec_in_valid),
    .dec_in_word(dec_in_word), .dec_in_ready(dec_in_ready), .dec_frame_ready(dec_frame_ready),
    .core_dec_addr(core_dec_addr), .dec_param_q(dec_param_q), .core_smp_wr(core_smp_wr),
    .core_smp_addr(core_smp_addr), .core_smp_data(core_smp_data), .dec_out_valid(dec_out_valid),
    .dec_out_sample(dec_out_sample), .state_init(state_init));

  harness_model u_harness (
    .core_clk(core_clk), .enc_in_valid(enc_in_valid), .enc_in_sample(enc_in_sample),
    .dec_in_valid(dec_in_valid), .dec_in_word(dec_in_word), .enc_out_ready(enc_out_ready));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ****************************************
  // event counters and coded word capture
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) n_play <= 0;
    else if (dec_out_valid === 1'b1) n_play <= n_play + 1;
    if (rst) n_init <= 0;
    else if (state_init === 1'b1) n_init <= n_init + 1;
    if (enc_core_valid === 1'b1) n_core <= n_core + 1;
    if (enc_core_valid === 1'b1) last_core <= enc_core_sample;
    if (enc_frame_end === 1'b1) n_end <= n_end + 1;
    if (dec_frame_ready === 1'b1) n_frm <= n_frm + 1;
    if (enc_out_valid === 1'b1 && enc_out_ready === 1'b1) begin
      got.push_back(enc_out);
      n_got <= n_got + 1;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic word_t pat(input int k);
    return {9'h1a5, k[6:0]};
  endfunction
  // low-bit mask of the field carried by word k
  function automatic word_t fmask(input int k);
    int w;
    int s;
    s = (k - 8) % 17;
    w = (k < 8) ? 6 - k / 2 : (s == 0) ? 7 : (s == 3) ? 6 : (s < 3) ? 2 : 3;
    return word_t'((32'h1 << w) - 1);
  endfunction
  task automatic chk_w(input word_t got_v, input word_t exp, input string m);
    n_checks++;
    if (got_v !== exp) begin
      fails++;
      $display("unexpected %0t %s: got %h want %h", $time, m, got_v, exp);
    end
  endtask
  task automatic chk_n(input logic [31:0] got_v, input logic [31:0] exp, input string m);
    n_checks++;
    if (got_v !== exp) begin
      fails++;
      $display("unexpected %0t %s: got %0d want %0d", $time, m, got_v, exp);
    end
  endtask
  task automatic wait_cnt(ref int c, input int t, input int lim, output int w);
    w = 0;
    while (c < t && w < lim) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    if (c < t) begin
      fails++;
      $display("unexpected %0t wait ran out", $time);
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_rst();
    int w;
    chk_n({enc_out_valid, dec_out_valid, enc_overrun}, 0, "outputs in reset");
    rst <= 1'b0;
    wait_cnt(n_init, 1, 4, w);
    chk_n(w, 1, "init after reset");
  endtask
  task automatic t_play();
    word_t m[160];
    int    w;
    for (int k = 0; k < 160; k++) begin
      m[k] = {k[7:0], 8'hc7};
      @(posedge core_clk);
      core_smp_wr   <= 1'b1;
      core_smp_addr <= k[7:0];
      core_smp_data <= m[k];
    end
    @(posedge core_clk);
    core_smp_wr <= 1'b0;
    wait_cnt(n_play, n_play + 1, SP + 2, w);
    for (int i = 0; i < 12; i++) begin
      wait_cnt(n_play, n_play + 1, SP + 2, w);
      chk_n(w, SP, "playout spacing");
      chk_w(dec_out_sample, m[(n_play - 1) % 160] & PAD_MASK, "playout sample");
    end
  endtask
  task automatic t_enc();
    int c0, e0, i0, w;
    c0 = n_core;
    e0 = n_end;
    i0 = n_init;
    u_harness.send_smp(16'h4a5f, 50, SP - 2);
    chk_n(n_core - c0, 50, "core samples");
    chk_w(last_core, 16'h4a58, "core sample");
    @(posedge core_clk);
    codec_state_reset <= 1'b1;
    wait_cnt(n_init, i0 + 1, 8, w);
    chk_n(w >= 4 && w <= 5, 1, "pin init delay");
    @(posedge core_clk);
    codec_state_reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    u_harness.send_smp(16'h4a58, 110, SP - 2);
    chk_n(n_end, e0, "frame end early");
    u_harness.send_smp(16'h7ff8, 50, SP - 2);
    chk_n(n_end, e0 + 1, "frame end");
    chk_n(n_init, i0 + 1, "no init on speech");
    u_harness.send_smp(EHW, 320, SP - 2);
    repeat (4) @(posedge core_clk);
    chk_n(n_init, i0 + 3, "init on homing");
  endtask
  task automatic t_out();
    int w;
    for (int k = 0; k < 76; k++) begin
      @(posedge core_clk);
      core_param_wr   <= 1'b1;
      core_param_addr <= k[6:0];
      core_param_data <= pat(k);
    end
    @(posedge core_clk);
    core_param_wr     <= 1'b0;
    core_params_done  <= 1'b1;
    u_harness.stall   <= 1'b1;
    @(posedge core_clk);
    core_params_done <= 1'b0;
    @(posedge core_clk);
    core_params_done <= 1'b1;
    @(posedge core_clk);
    core_params_done <= 1'b0;
    wait_cnt(n_got, 76, 400, w);
    repeat (20) @(posedge core_clk);
    chk_n(got.size(), 76, "coded words");
    chk_n(enc_overrun, 1, "overrun");
    for (int k = 0; k < 76 && k < got.size(); k++) begin
      chk_n(got[k].frame_start, k == 0, "frame start");
      chk_w(got[k].data, pat(k) & fmask(k), "coded word");
    end
  endtask
  task automatic t_dec();
    word_t q[$];
    word_t h[$];
    word_t r[$];
    int    f0, i0, w;
    for (int k = 0; k < 76; k++) q.push_back(pat(k) & fmask(k));
    for (int k = 0; k < 76; k++) r.push_back(pat(k));
    for (int k = 0; k < 76; k++) h.push_back(DHW);
    f0 = n_frm;
    i0 = n_init;
    u_harness.send_dec(r);
    chk_n(dec_in_ready, 1, "decoder ready");
    wait_cnt(n_frm, f0 + 1, 3, w);
    chk_n(w, 1, "decoder frame ready");
    for (int k = 0; k < 76; k++) begin
      @(posedge core_clk);
      core_dec_addr <= k[6:0];
      @(posedge core_clk);
      #1;
      chk_w(dec_param_q, q[k], "decoder word");
    end
    u_harness.send_dec(h);
    u_harness.send_dec(h);
    repeat (4) @(posedge core_clk);
    chk_n(n_init, i0 + 2, "decoder homing");
    f0 = n_frm;
    u_harness.send_dec(r);
    wait_cnt(n_frm, f0 + 1, 3, w);
    chk_n(w, 1, "frame after homing");
    @(posedge core_clk);
    core_dec_addr <= 7'h07;
    @(posedge core_clk);
    #1;
    chk_w(dec_param_q, q[7], "word after homing");
  endtask

  initial begin
    rst               = 1'b1;
    codec_state_reset = 1'b0;
    core_param_wr     = 1'b0;
    core_param_addr   = 7'h00;
    core_param_data   = 16'h0000;
    core_params_done  = 1'b0;
    core_dec_addr     = 7'h00;
    core_smp_wr       = 1'b0;
    core_smp_addr     = 8'h00;
    core_smp_data     = 16'h0000;
    repeat (6) @(posedge core_clk);
    t_rst();
    t_play();
    t_enc();
    t_out();
    t_dec();
    end_of_test();
  end
endmodule
`default_nettype wire
